// >>> src/urbe_bridge.sv
// Unaligned read burst expander: a FIFO module, an alignment module and the bridge top level.
// Assumes the upstream master and downstream slave share core_clk and that
// the downstream slave returns read beats in command order.
`default_nettype none

module urbe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  output logic [$clog2(DEPTH+1)-1:0] fill
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } urbe_fifo_state_s;

  urbe_fifo_state_s st;
  urbe_fifo_state_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             doPush;
  logic             doPop;

  assign inReady  = (st.cnt != CW'(DEPTH));
  assign outValid = (st.cnt != '0);
  assign outData  = mem[st.rp];
  assign fill     = st.cnt;
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // Pointers wrap by compare so any depth works, not only powers of two
  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    return (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    next_st = st;
    if (doPush) begin
      next_st.wp = ptr_next(st.wp);
    end
    if (doPop) begin
      next_st.rp = ptr_next(st.rp);
    end
    case ({doPush, doPop})
      2'b10:   next_st.cnt = st.cnt + 1'b1;
      2'b01:   next_st.cnt = st.cnt - 1'b1;
      default: next_st.cnt = st.cnt;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage has no reset; only the pointers and the count need a defined start
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[st.wp] <= inData;
    end
  end
endmodule : urbe_fifo

// Aligns one read: rounds the start down and the end up to whole slave words
module urbe_align #(
  parameter int ADDR_W  = 29,
  parameter int BURST_W = 7,
  parameter int RATIO   = 2
) (
  // Requested read, in master words
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic [BURST_W-1:0] burst,
  // Aligned read sent downstream
  output logic [ADDR_W-1:0]       alignAddr,
  output logic [BURST_W:0]        alignBurst,
  // Beats to drop ahead of the first requested word
  output logic [BURST_W:0]        skip
);
  localparam int DBW = BURST_W + 1;

  // RATIO is a power of two, so the low address bits select the word inside a slave word
  localparam logic [ADDR_W-1:0] MASK = ADDR_W'(RATIO - 1);

  logic [ADDR_W-1:0] lastWord;
  logic [ADDR_W-1:0] alignLast;
  logic [ADDR_W-1:0] spanWords;

  assign alignAddr  = addr & ~MASK;
  assign lastWord   = addr + ADDR_W'(burst) - 1'b1;
  // A slave word is fetched whole, so the end rounds up to its last master word
  assign alignLast  = lastWord | MASK;
  assign spanWords  = alignLast - alignAddr + 1'b1;
  // One extra bit holds the expansion while RATIO stays within the burst range
  assign alignBurst = DBW'(spanWords);
  assign skip       = DBW'(addr & MASK);
endmodule : urbe_align

module urbe_bridge #(
  parameter int DATA_W    = urbe_pkg::DATA_W,
  parameter int ADDR_W    = urbe_pkg::ADDR_W,
  parameter int BURST_W   = urbe_pkg::BURST_W,
  parameter int MAX_PEND  = urbe_pkg::MAX_PEND,
  parameter int SLAVE_W   = urbe_pkg::SLAVE_W,
  parameter int RSP_DEPTH = urbe_pkg::RSP_DEPTH,
  parameter bit PIPE_CMD  = urbe_pkg::PIPE_CMD
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // Upstream command (from the narrow master)
  input  wire logic                  upCmdValid,
  output logic                       upCmdReady,
  input  wire logic                  upCmdWrite,
  input  wire logic [ADDR_W-1:0]     upCmdAddr,
  input  wire logic [BURST_W-1:0]    upCmdBurst,
  input  wire logic [DATA_W-1:0]     upCmdWdata,
  input  wire logic [DATA_W/8-1:0]   upCmdBe,
  // Upstream read response
  output logic                       upRspValid,
  input  wire logic                  upRspReady,
  output logic [DATA_W-1:0]          upRspData,
  // Downstream command (to the wide slave side)
  output logic                       dnCmdValid,
  input  wire logic                  dnCmdReady,
  output logic                       dnCmdWrite,
  output logic [ADDR_W-1:0]          dnCmdAddr,
  output logic [BURST_W:0]           dnCmdBurst,
  output logic [DATA_W-1:0]          dnCmdWdata,
  output logic [DATA_W/8-1:0]        dnCmdBe,
  // Downstream read response
  input  wire logic                  dnRspValid,
  output logic                       dnRspReady,
  input  wire logic [DATA_W-1:0]     dnRspData,
  // Status
  output logic [$clog2(MAX_PEND+1)-1:0] pendReads
);
  // An illegal slave width falls back to no expansion rather than a broken mask
  localparam bit SLAVE_OK = (SLAVE_W >= urbe_pkg::SLAVE_W_MIN) && (SLAVE_W <= urbe_pkg::SLAVE_W_MAX)
                         && ((SLAVE_W & (SLAVE_W - 1)) == 0);
  localparam int RATIO = (SLAVE_OK && SLAVE_W > DATA_W) ? SLAVE_W / DATA_W : 1;
  localparam int DBW   = BURST_W + 1;
  localparam int TW    = 2 * DBW + BURST_W;
  localparam int PCW   = $clog2(MAX_PEND+1);

  typedef struct packed {
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [BURST_W-1:0]  burst;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W/8-1:0] be;
  } urbe_cmd_s;

  typedef struct packed {
    logic [DBW-1:0]     skip;
    logic [BURST_W-1:0] keep;
    logic [DBW-1:0]     total;
  } urbe_trk_s;

  typedef struct packed {
    logic           stgValid;
    urbe_cmd_s      stg;
    logic [DBW-1:0] beat;
  } urbe_state_s;

  urbe_state_s st;
  urbe_state_s next_st;

  urbe_cmd_s   upCmd;
  urbe_cmd_s   curCmd;
  logic        curValid;
  logic        curTake;
  logic        isRead;

  logic [ADDR_W-1:0] alignStart;
  logic [DBW-1:0]    alignBurst;
  logic [DBW-1:0]    alignSkip;
  logic              trkPush;
  logic [DBW-1:0]    winEnd;
  urbe_trk_s         trkIn;
  urbe_trk_s         trkHead;
  logic [TW-1:0]     trkHeadRaw;
  logic              trkInReady;
  logic              trkValid;
  logic              trkPop;

  logic              rbValid;
  logic [DATA_W-1:0] rbData;
  logic              rbPop;
  logic              inWindow;
  logic              lastBeat;

  // Upstream fields gathered into one carrier
  always_comb begin
    upCmd       = '0;
    upCmd.write = upCmdWrite;
    upCmd.addr  = upCmdAddr;
    upCmd.burst = upCmdBurst;
    upCmd.wdata = upCmdWdata;
    upCmd.be    = upCmdBe;
  end

  // Command source: either the register stage or the upstream port directly
  generate
    if (PIPE_CMD) begin : g_pipe
      assign curValid   = st.stgValid;
      assign curCmd     = st.stg;
      assign upCmdReady = !st.stgValid || curTake;
    end else begin : g_nopipe
      assign curValid   = upCmdValid;
      assign curCmd     = upCmd;
      assign upCmdReady = curTake;
    end
  endgenerate

  // Alignment arithmetic in master-word units
  assign isRead = !curCmd.write;

  urbe_align #(
    .ADDR_W  (ADDR_W),
    .BURST_W (BURST_W),
    .RATIO   (RATIO)
  ) u_align (
    .addr       (curCmd.addr),
    .burst      (curCmd.burst),
    .alignAddr  (alignStart),
    .alignBurst (alignBurst),
    .skip       (alignSkip)
  );

  always_comb begin
    trkIn       = '0;
    trkIn.skip  = alignSkip;
    trkIn.keep  = curCmd.burst;
    trkIn.total = alignBurst;
  end

  // A read waits while the tracking store is full, so no record is lost
  assign dnCmdValid = curValid && (!isRead || trkInReady);
  assign curTake    = dnCmdValid && dnCmdReady;

  always_comb begin
    dnCmdWrite = curCmd.write;
    dnCmdWdata = curCmd.wdata;
    dnCmdBe    = curCmd.be;
    if (isRead) begin
      dnCmdAddr  = alignStart;
      dnCmdBurst = alignBurst;
    end else begin
      dnCmdAddr  = curCmd.addr;
      dnCmdBurst = DBW'(curCmd.burst);
    end
  end

  // Push only when the read really leaves, so a stalled read records once
  assign trkPush = curValid && isRead && dnCmdReady && trkInReady;

  // One record per issued read, consumed in issue order
  urbe_fifo #(
    .WIDTH (TW),
    .DEPTH (MAX_PEND)
  ) u_trk (
    .core_clk (core_clk),
    .nrst     (nrst),
    .inValid  (trkPush),
    .inReady  (trkInReady),
    .inData   (trkIn),
    .outValid (trkValid),
    .outReady (trkPop),
    .outData  (trkHeadRaw),
    .fill     (pendReads)
  );

  assign trkHead = trkHeadRaw;

  // Response buffer; its ready pushes back on the downstream slave
  urbe_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (RSP_DEPTH)
  ) u_rsp (
    .core_clk (core_clk),
    .nrst     (nrst),
    .inValid  (dnRspValid),
    .inReady  (dnRspReady),
    .inData   (dnRspData),
    .outValid (rbValid),
    .outReady (rbPop),
    .outData  (rbData),
    .fill     ()
  );

  // Trim beats outside the original request window
  // Beat window of the oldest pending read
  assign winEnd   = trkHead.skip + DBW'(trkHead.keep);
  assign inWindow = (st.beat >= trkHead.skip) && (st.beat < winEnd);
  assign lastBeat = (st.beat == trkHead.total - 1'b1);

  assign upRspValid = rbValid && trkValid && inWindow;
  assign upRspData  = rbData;
  // Dropped beats drain without waiting for the master
  assign rbPop      = rbValid && trkValid && (!inWindow || upRspReady);
  assign trkPop     = rbPop && lastBeat;

  always_comb begin
    next_st = st;
    if (PIPE_CMD) begin
      if (upCmdValid && upCmdReady) begin
        next_st.stgValid = 1'b1;
        next_st.stg      = upCmd;
      end else if (curTake) begin
        next_st.stgValid = urbe_pkg::RST_VALID;
      end
    end
    if (rbPop) begin
      next_st.beat = lastBeat ? '0 : st.beat + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st          <= '0;
      st.stgValid <= urbe_pkg::RST_VALID;
      st.beat     <= DBW'(urbe_pkg::RST_COUNT);
    end else begin
      st <= next_st;
    end
  end
endmodule : urbe_bridge

`default_nettype wire

// >>> src/urbe_pkg.sv
// Constants shared by the read burst expander and its buffers.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none

package urbe_pkg;

  // Default build values of the top level
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 29;
  localparam int BURST_W   = 7;
  localparam int MAX_PEND  = 8;
  localparam int SLAVE_W   = 64;
  localparam int RSP_DEPTH = 32;
  localparam bit PIPE_CMD  = 1'b0;

  // Legal slave width range
  localparam int SLAVE_W_MIN = 16;
  localparam int SLAVE_W_MAX = 4096;

  // Values after reset
  localparam logic RST_VALID = 1'b0;
  localparam int   RST_COUNT = 0;

endpackage : urbe_pkg

`default_nettype wire

// >>> tb/urbe_bridge_properties.sv
// Port checker of the read burst expander top level.
// Assumes the command register stage is off, so dn follows up combinationally.
`default_nettype none
module urbe_bridge_props #(parameter int DATA_W = 32, ADDR_W = 29, BURST_W = 7, MAX_PEND = 8, SLAVE_W = 64) (
  // Clock and reset
  input wire logic core_clk, nrst,
  // Handshakes
  input wire logic upCmdValid, upCmdReady, upCmdWrite, upRspValid, upRspReady, dnCmdValid, dnCmdWrite,
  // Command and response values
  input wire logic [ADDR_W-1:0]  upCmdAddr, dnCmdAddr,
  input wire logic [BURST_W-1:0] upCmdBurst,
  input wire logic [BURST_W:0]   dnCmdBurst,
  input wire logic [DATA_W-1:0]  upRspData, upCmdWdata, dnCmdWdata,
  input wire logic [DATA_W/8-1:0] upCmdBe, dnCmdBe,
  input wire logic [$clog2(MAX_PEND+1)-1:0] pendReads
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [ADDR_W-1:0] M = ADDR_W'(SLAVE_W / DATA_W - 1);
  logic [ADDR_W-1:0] base, last;
  logic rdGo;
  assign base = upCmdAddr & ~M;
  assign last = (upCmdAddr + ADDR_W'(upCmdBurst) - 1'b1) | M;
  assign rdGo = upCmdValid && upCmdReady && !upCmdWrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence rdTake; rdGo; endsequence
  sequence rdDn; dnCmdValid && !dnCmdWrite; endsequence
  addr_round_a: assert property (rdDn |-> dnCmdAddr == base)
    else $error("read start not rounded down");
  burst_len_a: assert property (rdDn |-> dnCmdBurst == (BURST_W+1)'(last - base + 1'b1))
    else $error("read burst not stretched to slave word end");
  write_pass_a: assert property (dnCmdValid && dnCmdWrite |-> dnCmdAddr == upCmdAddr && dnCmdBurst == {1'b0, upCmdBurst})
    else $error("write command altered");
  wdata_pass_a: assert property (dnCmdValid && dnCmdWrite |-> dnCmdWdata == upCmdWdata && dnCmdBe == upCmdBe)
    else $error("write data altered");
  read_block_a: assert property (upCmdValid && !upCmdWrite && pendReads == MAX_PEND |-> !upCmdReady && !dnCmdValid)
    else $error("read taken beyond pending limit");
  pend_up_a: assert property (rdTake |=> pendReads != 0 && pendReads >= $past(pendReads))
    else $error("read taken without a record");
  pend_down_a: assert property (!rdGo |=> pendReads <= $past(pendReads))
    else $error("pending count grew without a read");
  rsp_hold_a: assert property (upRspValid && !upRspReady |=> upRspValid && $stable(upRspData))
    else $error("response word dropped while stalled");
  idle_rsp_a: assert property (pendReads == 0 |-> !upRspValid)
    else $error("response word with no read pending");
endmodule // urbe_bridge_props
bind urbe_bridge urbe_bridge_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .BURST_W(BURST_W), .MAX_PEND(MAX_PEND),
  .SLAVE_W(SLAVE_W)) i_props (.core_clk, .nrst, .upCmdValid, .upCmdReady, .upCmdWrite, .upRspValid, .upRspReady,
  .dnCmdValid, .dnCmdWrite, .upCmdAddr, .dnCmdAddr, .upCmdBurst, .dnCmdBurst, .upRspData, .upCmdWdata, .dnCmdWdata,
  .upCmdBe, .dnCmdBe, .pendReads);
`default_nettype wire

// >>> tb/urbe_slave_model.sv
// Wide-side slave model with random stalls on both channels.
// Assumes master-word units on the downstream port.
`default_nettype none
module urbe_slave_model (
  // Clock and reset
  input  wire logic        core_clk, nrst,
  // Command side
  input  wire logic        dnCmdValid, dnCmdWrite,
  output logic             dnCmdReady = 1'b0,
  input  wire logic [28:0] dnCmdAddr,
  input  wire logic [7:0]  dnCmdBurst,
  // Response side
  output logic             dnRspValid = 1'b0,
  input  wire logic        dnRspReady,
  output logic [31:0]      dnRspData = 32'h0000_0000
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [28:0] pend[$];
  logic        hold = 1'b0;
  logic        go;
  // Pure reads, one width, beats in command order
  always @(posedge core_clk) begin
    hold <= dnRspValid && !dnRspReady;
    if (!nrst) pend.delete();
    else begin
      if (dnCmdValid && dnCmdReady && !dnCmdWrite)
        for (int i = 0; i < dnCmdBurst; i++) pend.push_back(dnCmdAddr + 29'(i));
      if (dnRspValid && dnRspReady) void'(pend.pop_front());
    end
  end
  // Idle data toggles so a stale word is never mistaken for a fresh one
  always @(negedge core_clk) begin
    dnCmdReady <= $urandom % 4 != 0;
    go = nrst && pend.size() > 0 && (hold || $urandom % 3 != 0);
    dnRspValid <= go;
    dnRspData  <= go ? ({3'h0, pend[0]} ^ 32'h5A5A_0000) : ~dnRspData;
  end
endmodule // urbe_slave_model
`default_nettype wire

// >>> tb/test_unaligned_read_burst_expander.sv
// Self-checking bench of the read burst expander with a slave model.
// Assumes default build values and no command register stage.
`default_nettype none
module test_unaligned_read_burst_expander;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0, nrst = 1'b0, stall = 1'b0, w;
  logic        upCmdValid = 1'b0, upCmdWrite = 1'b0, upRspReady = 1'b0;
  logic [28:0] upCmdAddr = '0;
  logic [6:0]  upCmdBurst = '0;
  logic [31:0] upCmdWdata = '0, e;
  logic [3:0]  upCmdBe = '0;
  wire logic   upCmdReady, upRspValid, dnCmdValid, dnCmdReady, dnCmdWrite, dnRspValid, dnRspReady;
  wire logic [31:0] upRspData, dnCmdWdata, dnRspData;
  wire logic [28:0] dnCmdAddr;
  wire logic [7:0]  dnCmdBurst;
  wire logic [3:0]  dnCmdBe, pendReads;
  logic [31:0] expQ[$];
  int n_mismatch = 0, compares = 0;
  always #2.5 core_clk = ~core_clk;
  urbe_bridge i_dut (.core_clk, .nrst, .upCmdValid, .upCmdReady, .upCmdWrite, .upCmdAddr, .upCmdBurst, .upCmdWdata,
    .upCmdBe, .upRspValid, .upRspReady, .upRspData, .dnCmdValid, .dnCmdReady, .dnCmdWrite, .dnCmdAddr, .dnCmdBurst,
    .dnCmdWdata, .dnCmdBe, .dnRspValid, .dnRspReady, .dnRspData, .pendReads);
  urbe_slave_model i_slave (.core_clk, .nrst, .dnCmdValid, .dnCmdWrite, .dnCmdReady, .dnCmdAddr, .dnCmdBurst,
    .dnRspValid, .dnRspReady, .dnRspData);
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Called at a falling edge; leaves the command up so the next one follows back to back
  task automatic cmd(input logic wr, input logic [28:0] a, input logic [6:0] n);
    upCmdValid = 1'b1;
    upCmdWrite = wr;
    upCmdAddr  = a;
    upCmdBurst = n;
    upCmdWdata = $urandom;
    upCmdBe    = 4'hF;
    if (!wr) for (int i = 0; i < n; i++) expQ.push_back({3'h0, a + 29'(i)} ^ 32'h5A5A_0000);
    #1;
    for (int k = 0; k < 999 && !upCmdReady; k++) begin
      @(negedge core_clk);
      #1;
    end
    if (!upCmdReady) n_mismatch++;
    @(negedge core_clk);
  endtask
  always @(negedge core_clk) upRspReady <= !stall && $urandom % 4 != 0;
  always @(posedge core_clk) if (nrst && upRspValid && upRspReady) begin
    e = expQ.size() ? expQ.pop_front() : 'x;
    chk("upRspData", e, upRspData);
  end
  initial begin
    #60000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    void'($urandom(10));
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    cmd(1'b0, 29'h0000_0001, 7'h08);
    for (int a = 4; a < 6; a++) for (int n = 1; n < 4; n++) cmd(1'b0, 29'(a), 7'(n));
    repeat (40) begin
      w = $urandom % 4 == 0;
      cmd(w, 29'($urandom % 4096), w ? 7'h01 : 7'($urandom % 16 + 1));
    end
    // Drain first, so the stalled reads below fill the pending limit exactly
    upCmdValid = 1'b0;
    repeat (600) @(negedge core_clk);
    chk("pendReads", 32'h0000_0000, 32'(pendReads));
    // Stalled master: the pending limit refuses a read while the response buffer fills
    stall = 1'b1;
    repeat (8) cmd(1'b0, 29'($urandom % 512 * 8), 7'h08);
    fork
      cmd(1'b0, 29'h0000_0003, 7'h03);
      begin
        repeat (100) @(negedge core_clk);
        stall = 1'b0;
      end
    join
    upCmdValid = 1'b0;
    repeat (400) @(negedge core_clk);
    chk("pendReads", 32'h0000_0000, 32'(pendReads));
    chk("leftover", 32'h0000_0000, 32'(expQ.size()));
    wrap_up;
  end
endmodule // test_unaligned_read_burst_expander
`default_nettype wire
